// File: cpu_bus_model.sv
// Purpose: CPU core model on the EEPROM memory bus and power lines.
// Assumes: One clock; each access strobe lasts one cycle.
// Notes: An undriven data bus reads as the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
	import eeprom_ctrl_pkg::*;
(
	input wire logic sys_clk,
	output logic cpuSel,
	output logic cpuRd,
	output logic cpuWr,
	output logic [ADDR_W-1:0] cpuAddr,
	output logic [DATA_W-1:0] cpuWdata,
	input wire logic [DATA_W-1:0] cpuRdata,
	input wire logic cpuRdataOe,
	output logic waitReq,
	output logic haltReq,
	output logic intAck
);
	logic [DATA_W-1:0] lastBus = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Idle bus and power lines
	initial begin
		{cpuSel, cpuRd, cpuWr, waitReq, haltReq, intAck} = 6'h00;
		cpuAddr = 8'h00;
		cpuWdata = 8'h00;
	end

	// One write strobe; callers keep one row between programs
	task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{cpuSel, cpuWr} <= 2'h3;
		cpuAddr <= a;
		cpuWdata <= d;
		@(posedge sys_clk);
		{cpuSel, cpuWr} <= 2'h0;
	endtask : busWrite

	// One read strobe; resolves the shared data bus
	task automatic busRead(input logic [7:0] a, output logic [7:0] d,
		output logic oe);
		@(posedge sys_clk);
		{cpuSel, cpuRd} <= 2'h3;
		cpuAddr <= a;
		@(posedge sys_clk);
		{cpuSel, cpuRd} <= 2'h0;
		#1;
		oe = cpuRdataOe;
		d = oe ? cpuRdata : ~lastBus;
		lastBus = d;
	endtask : busRead

	// Wait and halt levels; a halt cuts a running cycle short
	task automatic power(input logic w, input logic h);
		@(posedge sys_clk);
		waitReq <= w;
		haltReq <= h;
	endtask : power

	// Vector fetch of the end-of-programming routine
	task automatic ackPulse();
		@(posedge sys_clk);
		intAck <= 1'b1;
		@(posedge sys_clk);
		intAck <= 1'b0;
	endtask : ackPulse
endmodule : cpu_bus_model
`default_nettype wire

// File: data_eeprom_program_control_tb.sv
// Purpose: Self-checking bench for the EEPROM program control.
// Assumes: AXI4-Lite master tasks; CPU side via the bus model.
// Notes: Full programming time is used; no parameter shortening.
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_program_control_tb import eeprom_ctrl_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic cpuSel, cpuRd, cpuWr, cpuRdataOe, waitReq, haltReq, intAck;
	logic [7:0] cpuAddr, cpuWdata, cpuRdata, bd;
	logic eeWaitState, eeHalted, eeIrq, irq, ob;
	int nFail = 0;
	int comparisons = 0;
	int cyc = 0;

	////////////////////////////////////////////////////////////////////
	// Clock and cycle count
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	eeprom_prog_ctrl i_eeprom_prog_ctrl (.sys_clk, .rst_n, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpuSel,
		.cpuRd, .cpuWr, .cpuAddr, .cpuWdata, .cpuRdata, .cpuRdataOe,
		.waitReq, .haltReq, .intAck, .eeWaitState, .eeHalted, .eeIrq, .irq);
	cpu_bus_model i_cpu_bus_model (.sys_clk, .cpuSel, .cpuRd, .cpuWr,
		.cpuAddr, .cpuWdata, .cpuRdata, .cpuRdataOe, .waitReq, .haltReq,
		.intAck);

	////////////////////////////////////////////////////////////////////
	// Compare, report and close
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("fails=%0d comparisons=%0d", nFail, comparisons);
		if (nFail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic timeOut();
		nFail++;
		summarize();
	endtask : timeOut

	// Write with both channels offered together
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic tAw, tW, b;
		b = 1'b0;
		@(posedge sys_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		for (int n = 0; n < 50 && !b; n++) begin
			@(negedge sys_clk);
			tAw = s_axi_awvalid && s_axi_awready;
			tW = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (tAw) s_axi_awvalid <= 1'b0;
			if (tW) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b) timeOut();
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic tAr, got;
		got = 1'b0;
		@(posedge sys_clk);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		s_axi_araddr <= a;
		for (int n = 0; n < 50 && !got; n++) begin
			@(negedge sys_clk);
			tAr = s_axi_arvalid && s_axi_arready;
			got = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (tAr) s_axi_arvalid <= 1'b0;
			if (got) s_axi_rready <= 1'b0;
		end
		if (!got) timeOut();
	endtask : axiRead

	task automatic regIs(input logic [7:0] a, input logic [7:0] e);
		axiRead(a, rd, rsp);
		check(rd, {24'h00_0000, e});
		check(32'(rsp), 32'(RESP_OKAY));
	endtask : regIs

	task automatic regSet(input logic [7:0] a, input logic [7:0] d);
		axiWrite(a, d, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
	endtask : regSet

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	////////////////////////////////////////////////////////////////////
	// Reset values, unmapped place, reserved bits
	task automatic scenResetMap();
		regIs(CSR_OFFSET, CSR_RESET);
		regIs(IRQ_STATUS_OFFSET, 8'h00);
		check(32'({eeIrq, irq, eeWaitState}), 32'h0000_0000);
		axiRead(8'h40, rd, rsp);
		check({rd[29:0], rsp}, 32'(RESP_SLVERR));
		axiWrite(8'h40, 8'hFF, rsp);
		check(32'(rsp), 32'(RESP_SLVERR));
		regSet(CSR_OFFSET, 8'hF8);
		regIs(CSR_OFFSET, 8'h00);
	endtask : scenResetMap

	// Access errors in each mode, with interrupt mask
	task automatic scenAccessErrors();
		regSet(IRQ_MASK_OFFSET, 8'h07);
		regIs(IRQ_MASK_OFFSET, 8'h07);
		i_cpu_bus_model.busWrite(8'h31, 8'h3C);
		settle(1);
		check(32'(irq), 32'h0000_0001);
		regIs(IRQ_STATUS_OFFSET, 8'h02);
		regIs(IRQ_STATUS_OFFSET, 8'h00);
		check(32'(irq), 32'h0000_0000);
		regSet(CSR_OFFSET, 8'hFE);
		regIs(CSR_OFFSET, 8'h06);
		i_cpu_bus_model.busRead(8'h20, bd, ob);
		check(32'(ob), 32'h0000_0000);
		regIs(IRQ_STATUS_OFFSET, 8'h04);
	endtask : scenAccessErrors

	// Full row program with wait pending, then readback
	task automatic scenProgram();
		int t0;
		logic [7:0] v;
		i_cpu_bus_model.busWrite(8'h2F, 8'hF0);
		for (int i = 0; i < LATCH_COUNT; i++)
			i_cpu_bus_model.busWrite(8'h20 + 8'(i), 8'h3C + 8'(i));
		regSet(CSR_OFFSET, 8'h07);
		t0 = cyc;
		regIs(CSR_OFFSET, 8'h07);
		regSet(CSR_OFFSET, 8'h05);
		regIs(CSR_OFFSET, 8'h07);
		i_cpu_bus_model.power(1'b1, 1'b0);
		settle(3);
		check(32'(eeWaitState), 32'h0000_0000);
		for (int n = 0; n < 3000 && !eeIrq; n++) settle(1);
		if (!eeIrq) timeOut();
		check(32'(cyc - t0 >= PROG_CYCLES), 32'h0000_0001);
		check(32'(cyc - t0 <= PROG_CYCLES + 20), 32'h0000_0001);
		settle(2);
		check(32'(eeWaitState), 32'h0000_0001);
		regIs(CSR_OFFSET, 8'h04);
		check(32'(eeIrq), 32'h0000_0001);
		regIs(IRQ_STATUS_OFFSET, 8'h01);
		i_cpu_bus_model.ackPulse();
		settle(1);
		check(32'(eeIrq), 32'h0000_0000);
		i_cpu_bus_model.power(1'b0, 1'b0);
		settle(2);
		for (int i = 0; i < LATCH_COUNT; i++) begin
			v = 8'h3C + 8'(i);
			if (i == 15) v = v & 8'hF0;
			i_cpu_bus_model.busRead(8'h20 + 8'(i), bd, ob);
			check(32'({ob, bd}), 32'({1'b1, v}));
		end
	endtask : scenProgram

	// Wait when idle, halt mid-cycle, program without enable
	task automatic scenPower();
		i_cpu_bus_model.power(1'b1, 1'b0);
		settle(1);
		check(32'(eeWaitState), 32'h0000_0001);
		i_cpu_bus_model.power(1'b0, 1'b0);
		regSet(CSR_OFFSET, 8'h06);
		i_cpu_bus_model.busWrite(8'h50, 8'h11);
		regSet(CSR_OFFSET, 8'h07);
		settle(10);
		i_cpu_bus_model.power(1'b0, 1'b1);
		settle(1);
		check(32'(eeHalted), 32'h0000_0001);
		regIs(CSR_OFFSET, 8'h06);
		i_cpu_bus_model.power(1'b0, 1'b0);
		settle(2500);
		check(32'({eeHalted, eeIrq}), 32'h0000_0000);
		regIs(IRQ_STATUS_OFFSET, 8'h00);
		regSet(CSR_OFFSET, 8'h00);
		regIs(CSR_OFFSET, 8'h00);
		regSet(CSR_OFFSET, 8'h03);
		for (int n = 0; n < 3000 && !irq; n++) settle(1);
		if (!irq) timeOut();
		check(32'({irq, eeIrq}), 32'h0000_0002);
		regIs(CSR_OFFSET, 8'h00);
	endtask : scenPower

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		scenResetMap();
		scenAccessErrors();
		scenProgram();
		scenPower();
		summarize();
	end
endmodule : data_eeprom_program_control_tb
`default_nettype wire

// File: eeprom_byte_array.sv
// Purpose: 256-byte storage array with one write and one read port.
// Assumes: Write and read may hit the same word; read returns old data.
// Notes: Read data come out of a register one edge after the address.
`default_nettype none
`timescale 1ns/1ps
module eeprom_byte_array
	import eeprom_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [ARRAY_DEPTH];

	// Array write
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read
	always_ff @(posedge sys_clk) begin
		rdData <= mem[rdAddr];
	end
endmodule : eeprom_byte_array
`default_nettype wire

// File: eeprom_ctrl_pkg.sv
// Purpose: Shared constants and types for the data EEPROM program control.
// Assumes: One 200 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses; every register is one aligned word.
`default_nettype none
package eeprom_ctrl_pkg;
	// Array and latch geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int ARRAY_DEPTH = 256;
	localparam int LATCH_COUNT = 16;
	localparam int LATCH_IDX_W = 4;
	localparam int ROW_W = 4;
	localparam logic [LATCH_IDX_W-1:0] LAST_LATCH = 4'hF;

	// Register offsets and reset values
	localparam logic [7:0] CSR_OFFSET = 8'h2C;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h30;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h34;
	localparam logic [7:0] CSR_RESET = 8'h00;

	// Control/status field positions
	localparam int CSR_PGM_BIT = 0;
	localparam int CSR_LAT_BIT = 1;
	localparam int CSR_IE_BIT = 2;

	// Sticky event layout, shared by status and mask
	localparam int EV_W = 3;
	localparam int EV_DONE = 0;
	localparam int EV_WR_IGNORED = 1;
	localparam int EV_RD_FLOAT = 2;
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;

	// Programming cycle timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PROG_TIME_NS = 10000;
	localparam int PROG_CYCLES =
		(PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PROG_CNT_W = 12;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PROG = 5'h02,
		ST_COMMIT = 5'h04,
		ST_WAIT = 5'h08,
		ST_HALT = 5'h10
	} eeState_t;
endpackage : eeprom_ctrl_pkg
`default_nettype wire

// File: eeprom_prog_ctrl.sv
// Purpose: Data EEPROM program control with AXI4-Lite registers.
// Assumes: CPU bus, wait and halt signals share sys_clk; no synchronisers.
// Notes: Programming commits latched bytes after an internal delay.
//
// Overview of operation
// - Wait instruction with no cycle running enters wait state at once.
// - Wait during programming finishes the cycle, then enters wait.
// - Halt stops at once, abandoning any cycle; data may be bad.
// - Reads of the array in write mode leave the data bus undriven.
// - Writes to the array in read mode are ignored, nothing latched.
// - Control/status bits 7 to 3 always read as zero.
// - Interrupt enable bit 2 allows a request when programming ends.
// - Pending end request clears when the CPU enters its routine.
// - Write-mode bit 1 set by software, cleared by hardware at end.
// - Software may clear write mode only while programming bit is zero.
// - Writing one to bit 0 starts programming; reads one meanwhile.
// - At cycle end hardware clears bit 0 and raises enabled request.
// - Control/status register sits at 002Ch and resets to zero.
// - Write-mode array writes land in 16 latches by low address bits.
// - Programmed row comes from the upper address of the last write.
// - Latches clear only at cycle end and write-mode falling edge.
// - Read mode returns the addressed byte one clock later.
//
// Design decision made here: the AXI4-Lite register port.
`default_nettype none
`timescale 1ns/1ps
module eeprom_prog_ctrl
	import eeprom_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// CPU memory bus to the EEPROM area
	input wire logic cpuSel,
	input wire logic cpuRd,
	input wire logic cpuWr,
	input wire logic [ADDR_W-1:0] cpuAddr,
	input wire logic [DATA_W-1:0] cpuWdata,
	output logic [DATA_W-1:0] cpuRdata,
	output logic cpuRdataOe,
	// Power modes and interrupts
	input wire logic waitReq,
	input wire logic haltReq,
	input wire logic intAck,
	output logic eeWaitState,
	output logic eeHalted,
	output logic eeIrq,
	output logic irq
);
	// Register hit decode shared by write and read paths
	function automatic logic regHit(input logic [7:0] a,
		input logic [7:0] off);
		regHit = (a[7:2] == off[7:2]);
	endfunction : regHit

	eeState_t st_r;
	logic pgm_r, lat_r, ie_r, latPrev_r;
	logic [PROG_CNT_W-1:0] progCnt_r;
	logic [LATCH_IDX_W-1:0] commitIdx_r;
	logic [ROW_W-1:0] row_r;
	logic [EV_W-1:0] irqStat_r, irqMask_r, evSet, evClr;
	logic awTaken_r, wTaken_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic regWe, csrWe, startReq, abortReq, progEnd, busy, latFall;
	logic arHs, latchWe, latchClr, latchValid, arrayWe, mapped;
	logic [DATA_W-1:0] latchData, arrayRdata;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data in either order
	assign s_axi_awready = !awTaken_r && !s_axi_bvalid;
	assign s_axi_wready = !wTaken_r && !s_axi_bvalid;
	assign regWe = awTaken_r && wTaken_r && !s_axi_bvalid;
	assign mapped = regHit(awAddr_r, CSR_OFFSET) ||
		regHit(awAddr_r, IRQ_STATUS_OFFSET) ||
		regHit(awAddr_r, IRQ_MASK_OFFSET);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awTaken_r <= 1'b0;
			wTaken_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awTaken_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wTaken_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (regWe) begin
				awTaken_r <= 1'b0;
				wTaken_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel; reserved bits read as zero
	assign s_axi_arready = !s_axi_rvalid;
	assign arHs = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (arHs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			if (regHit(s_axi_araddr, CSR_OFFSET)) begin
				s_axi_rdata <= {29'h0, ie_r, lat_r, pgm_r};
			end else if (regHit(s_axi_araddr, IRQ_STATUS_OFFSET)) begin
				s_axi_rdata <= {29'h0, irqStat_r};
			end else if (regHit(s_axi_araddr, IRQ_MASK_OFFSET)) begin
				s_axi_rdata <= {29'h0, irqMask_r};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control/status bits
	assign csrWe = regWe && regHit(awAddr_r, CSR_OFFSET) && wStrb_r[0];
	assign busy = (st_r == ST_PROG) || (st_r == ST_COMMIT);
	assign startReq = csrWe && wData_r[CSR_PGM_BIT] && (st_r == ST_IDLE)
		&& !haltReq;
	assign abortReq = csrWe && !wData_r[CSR_PGM_BIT] && busy && !haltReq;
	assign progEnd = (st_r == ST_COMMIT) && (commitIdx_r == LAST_LATCH)
		&& !haltReq;

	// Programming bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pgm_r <= CSR_RESET[CSR_PGM_BIT];
		end else if (haltReq || progEnd || abortReq) begin
			pgm_r <= 1'b0;
		end else if (startReq) begin
			pgm_r <= 1'b1;
		end
	end

	// Write-mode bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_r <= CSR_RESET[CSR_LAT_BIT];
		end else if (progEnd) begin
			lat_r <= 1'b0;
		end else if (csrWe) begin
			if (wData_r[CSR_LAT_BIT]) begin
				lat_r <= 1'b1;
			end else if (!pgm_r) begin
				lat_r <= 1'b0;
			end
		end
	end

	// Interrupt enable and falling-edge tracker of write mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_r <= CSR_RESET[CSR_IE_BIT];
			latPrev_r <= 1'b0;
		end else begin
			latPrev_r <= lat_r;
			if (csrWe) begin
				ie_r <= wData_r[CSR_IE_BIT];
			end
		end
	end
	assign latFall = latPrev_r && !lat_r;

	////////////////////////////////////////////////////////////////////
	// Cycle sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
		end else if (haltReq) begin
			st_r <= ST_HALT;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (startReq) begin
						st_r <= ST_PROG;
					end else if (waitReq) begin
						st_r <= ST_WAIT;
					end
				end
				ST_PROG: begin
					if (abortReq) begin
						st_r <= ST_IDLE;
					end else if (progCnt_r ==
						PROG_CNT_W'(PROG_CYCLES - 1)) begin
						st_r <= ST_COMMIT;
					end
				end
				ST_COMMIT: begin
					if (abortReq) begin
						st_r <= ST_IDLE;
					end else if (progEnd) begin
						st_r <= waitReq ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (!waitReq) begin
						st_r <= ST_IDLE;
					end
				end
				ST_HALT: begin
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Delay counter and commit walk
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			progCnt_r <= '0;
			commitIdx_r <= '0;
		end else begin
			progCnt_r <= (st_r == ST_PROG) ? progCnt_r + 1'b1 : '0;
			commitIdx_r <= (st_r == ST_COMMIT) ? commitIdx_r + 1'b1 : '0;
		end
	end

	assign eeWaitState = (st_r == ST_WAIT);
	assign eeHalted = (st_r == ST_HALT);

	////////////////////////////////////////////////////////////////////
	// CPU side: latch capture, row tracking, array read
	assign latchWe = cpuSel && cpuWr && lat_r && !eeHalted;
	assign latchClr = progEnd || latFall;
	assign arrayWe = (st_r == ST_COMMIT) && latchValid && !haltReq;

	// Row of the most recent latched write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_r <= '0;
		end else if (latchWe) begin
			row_r <= cpuAddr[ADDR_W-1:LATCH_IDX_W];
		end
	end

	// Drive enable for read data, one clock after the access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuRdataOe <= 1'b0;
		end else begin
			cpuRdataOe <= cpuSel && cpuRd && !lat_r && !eeHalted;
		end
	end
	assign cpuRdata = arrayRdata;

	eeprom_row_latch uLatch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.capWe(latchWe),
		.capIdx(cpuAddr[LATCH_IDX_W-1:0]),
		.capData(cpuWdata),
		.clr(latchClr),
		.rdIdx(commitIdx_r),
		.rdData(latchData),
		.rdValid(latchValid)
	);

	eeprom_byte_array uArray (
		.sys_clk(sys_clk),
		.wrEn(arrayWe),
		.wrAddr({row_r, commitIdx_r}),
		.wrData(latchData),
		.rdAddr(cpuAddr),
		.rdData(arrayRdata)
	);

	////////////////////////////////////////////////////////////////////
	// End-of-programming request; set wins over acknowledge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eeIrq <= 1'b0;
		end else if (progEnd && ie_r) begin
			eeIrq <= 1'b1;
		end else if (intAck) begin
			eeIrq <= 1'b0;
		end
	end

	// Sticky events, cleared by reading the status register
	assign evSet = {cpuSel && cpuRd && lat_r,
		cpuSel && cpuWr && !lat_r, progEnd};
	assign evClr = (arHs && regHit(s_axi_araddr, IRQ_STATUS_OFFSET)) ?
		{EV_W{1'b1}} : EV_RESET;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_r <= EV_RESET;
		end else begin
			irqStat_r <= (irqStat_r & ~evClr) | evSet;
		end
	end

	// Mask register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqMask_r <= EV_RESET;
		end else if (regWe && regHit(awAddr_r, IRQ_MASK_OFFSET) &&
			wStrb_r[0]) begin
			irqMask_r <= wData_r[EV_W-1:0];
		end
	end
	assign irq = |(irqStat_r & irqMask_r);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence startSeq;
		startReq ##1 (st_r == ST_PROG);
	endsequence

	waitEnter_a: assert property ((st_r == ST_IDLE) && waitReq && !haltReq && !startReq |=> eeWaitState) else $error("wait not entered");
	waitDefer_a: assert property (busy && waitReq && !haltReq && !progEnd |=> !eeWaitState) else $error("wait entered mid cycle");
	haltStop_a: assert property (haltReq |=> eeHalted && !pgm_r && !arrayWe) else $error("halt not immediate");
	readFloat_a: assert property (cpuSel && cpuRd && lat_r |=> !cpuRdataOe) else $error("bus driven in write mode");
	writeIgnore_a: assert property (cpuSel && cpuWr && !lat_r |=> $stable(row_r)) else $error("write latched in read mode");
	rsvdZero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0) else $error("reserved bits nonzero");
	irqRaise_a: assert property (progEnd && ie_r |=> eeIrq ##0 (st_r != ST_COMMIT)) else $error("end request missing");
	irqQuiet_a: assert property (progEnd && !ie_r && !eeIrq |=> !eeIrq) else $error("request without enable");
	irqAck_a: assert property (intAck && !(progEnd && ie_r) |=> !eeIrq) else $error("request not cleared");
	endClear_a: assert property (progEnd |=> !pgm_r && !lat_r ##1 !latchValid) else $error("end did not clear");
	latHold_a: assert property (csrWe && pgm_r && lat_r && !progEnd |=> lat_r) else $error("write mode cleared while busy");
	pgmStart_a: assert property (startSeq |-> pgm_r [*8]) else $error("program bit not held");
	rdReturn_a: assert property (cpuSel && cpuRd && !lat_r && !eeHalted |=> cpuRdataOe && cpuRdata == uArray.mem[$past(cpuAddr)]) else $error("read data missing");
	progTime_a: assert property ((st_r == ST_PROG) && progCnt_r < PROG_CNT_W'(PROG_CYCLES - 1) |=> st_r != ST_COMMIT) else $error("commit too early");
endmodule : eeprom_prog_ctrl
`default_nettype wire

// File: eeprom_row_latch.sv
// Purpose: Sixteen byte latches that collect one row before programming.
// Assumes: Capture and clear never need to happen in the same cycle.
// Notes: A second write to a filled latch ANDs into it (over-program).
`default_nettype none
`timescale 1ns/1ps
module eeprom_row_latch
	import eeprom_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic capWe,
	input wire logic [LATCH_IDX_W-1:0] capIdx,
	input wire logic [DATA_W-1:0] capData,
	input wire logic clr,
	input wire logic [LATCH_IDX_W-1:0] rdIdx,
	output logic [DATA_W-1:0] rdData,
	output logic rdValid
);
	logic [DATA_W-1:0] latchData_r [LATCH_COUNT];
	logic [LATCH_COUNT-1:0] latchValid_r;

	// One latch per slot; clear wins over capture
	for (genvar i = 0; i < LATCH_COUNT; i++) begin : gSlot
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				latchData_r[i] <= 8'h00;
				latchValid_r[i] <= 1'b0;
			end else if (clr) begin
				latchData_r[i] <= 8'h00;
				latchValid_r[i] <= 1'b0;
			end else if (capWe && capIdx == LATCH_IDX_W'(i)) begin
				latchData_r[i] <= latchValid_r[i] ?
					(latchData_r[i] & capData) : capData;
				latchValid_r[i] <= 1'b1;
			end
		end
	end

	// Commit side view of one slot
	assign rdData = latchData_r[rdIdx];
	assign rdValid = latchValid_r[rdIdx];
endmodule : eeprom_row_latch
`default_nettype wire
